// ### logic/wwd_top.sv
// Window watchdog core: probing, window timing, fault hold
`timescale 1ns/1ps
module wwd_top import wwd_pkg::*; #(
	// Capacitor-set times: the charge itself is analogue, outside this logic
	parameter logic [CW-1:0] CAP_UPPER_CYC = wwd_us2cyc(CAP_UP_US),
	parameter logic [CW-1:0] CAP_HOLD_CYC  = wwd_us2cyc(CAP_HOLD_US),
	// Preset hold times
	parameter logic [CW-1:0] HOLD_OPEN_CYC = wwd_us2cyc(HOLD_OPEN_US),
	parameter logic [CW-1:0] HOLD_PU_CYC   = wwd_us2cyc(HOLD_PU_US),
	// Preset window bounds, window pin open
	parameter logic [CW-1:0] LO_OPEN00_CYC = wwd_us2cyc(LO_OPEN_00),
	parameter logic [CW-1:0] LO_OPEN01_CYC = wwd_us2cyc(LO_OPEN_01),
	parameter logic [CW-1:0] LO_OPEN11_CYC = wwd_us2cyc(LO_OPEN_11),
	parameter logic [CW-1:0] UP_OPEN00_CYC = wwd_us2cyc(UP_OPEN_00),
	parameter logic [CW-1:0] UP_OPEN01_CYC = wwd_us2cyc(UP_OPEN_01),
	parameter logic [CW-1:0] UP_OPEN11_CYC = wwd_us2cyc(UP_OPEN_11),
	// Preset window bounds, window pin pulled up
	parameter logic [CW-1:0] LO_PU00_CYC   = wwd_us2cyc(LO_PU_00),
	parameter logic [CW-1:0] LO_PU01_CYC   = wwd_us2cyc(LO_PU_01),
	parameter logic [CW-1:0] LO_PU11_CYC   = wwd_us2cyc(LO_PU_11),
	parameter logic [CW-1:0] UP_PU00_CYC   = wwd_us2cyc(UP_PU_00),
	parameter logic [CW-1:0] UP_PU01_CYC   = wwd_us2cyc(UP_PU_01),
	parameter logic [CW-1:0] UP_PU11_CYC   = wwd_us2cyc(UP_PU_11)
) (
	input  wire logic       mclk,
	input  wire logic       rstn,
	input  wire logic       ce,
	input  wire logic       uvlo,
	input  wire logic       kick_input,
	input  wire logic       window_select_0,
	input  wire logic       window_select_1,
	input  wire wwd_probe_t window_timing_pin,
	input  wire wwd_probe_t delay_timing_pin,
	output logic            fault_output_n,
	output logic            enabled,
	output logic [1:0]      window_kind,
	output logic [1:0]      hold_kind
);
	typedef enum logic [2:0] {
		ST_PROBE  = 3'b000,
		ST_INIT   = 3'b001,
		ST_OFF    = 3'b010,
		ST_SETTLE = 3'b011,
		ST_FIRST  = 3'b100,
		ST_WIN    = 3'b101,
		ST_FAULT  = 3'b110
	} wwd_state_t;

	logic       rs1_q;
	logic       rs2_q;
	logic       rst_n;
	logic [3:0] pins_s;
	logic       kick_s;
	logic       uv_s;
	logic       sel0_s;
	logic       sel1_s;
	wwd_probe_t wprb_s, dprb_s;
	wwd_pin_t   wkind, dkind;
	logic       wdone;

	// Reset released through two flops, asserted at once
	// A raw release could reach the flops on different edges
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rs1_q <= 1'b0;
			rs2_q <= 1'b0;
		end else begin
			rs1_q <= 1'b1;
			rs2_q <= rs1_q;
		end
	end
	assign rst_n = rs2_q;

	// Pins arrive asynchronously
	wwd_sync #(.W(6)) u_sync_ctl (
		.mclk (mclk),
		.rst_n(rst_n),
		.ce   (ce),
		.din  ({kick_input, uvlo, window_select_0, window_select_1}),
		.dout (pins_s)
	);
	wwd_sync #(.W(4)) u_sync_prb (
		.mclk (mclk),
		.rst_n(rst_n),
		.ce   (ce),
		.din  ({window_timing_pin, delay_timing_pin}),
		.dout ({wprb_s, dprb_s})
	);
	assign kick_s = pins_s[3];
	assign uv_s   = pins_s[2];
	assign sel0_s = pins_s[1];
	assign sel1_s = pins_s[0];

	// Sequencer state, held select code and registered outputs
	logic          pstart_q, pstart_d;
	wwd_state_t    st_q, st_d;
	logic [CW-1:0] cnt_q, cnt_d;
	logic [1:0]    sel_q, sel_d;
	logic          kick_q, kick_d;
	logic          capfault_q, capfault_d;
	logic          wdo_q, wdo_d;
	logic          en_q, en_d;
	logic [1:0]    live;
	logic          dis_now;
	logic          fall;
	wwd_win_t      win;
	logic [CW-1:0] hold;

	// One classifier per timing pin, both started and ended together
	wwd_probe u_probe_win (
		.mclk (mclk),
		.rst_n(rst_n),
		.ce   (ce),
		.start(pstart_q),
		.obs  (wprb_s),
		.kind (wkind),
		.done (wdone)
	);
	wwd_probe u_probe_del (
		.mclk (mclk),
		.rst_n(rst_n),
		.ce   (ce),
		.start(pstart_q),
		.obs  (dprb_s),
		.kind (dkind),
		.done ()
	);

	// Live select code and kick edge; a rising kick is never a kick
	assign live    = {sel1_s, sel0_s};
	assign dis_now = (live == SEL_DIS);
	assign fall    = kick_q & ~kick_s;

	// Window lookup from latched select and window pin class
	// Capacitor ratios are shifts, so 1/8 and 1/2 lower bounds truncate; the 3/4 one rounds up
	always_comb begin
		win = '0;
		unique case (wkind)
		PIN_OPEN: begin
			unique case (sel_q)
			SEL_00:  win = '{LO_OPEN00_CYC, UP_OPEN00_CYC};
			SEL_01:  win = '{LO_OPEN01_CYC, UP_OPEN01_CYC};
			SEL_11:  win = '{LO_OPEN11_CYC, UP_OPEN11_CYC};
			SEL_DIS: win = '0;
			endcase
		end
		PIN_PU: begin
			unique case (sel_q)
			SEL_00:  win = '{LO_PU00_CYC, UP_PU00_CYC};
			SEL_01:  win = '{LO_PU01_CYC, UP_PU01_CYC};
			SEL_11:  win = '{LO_PU11_CYC, UP_PU11_CYC};
			SEL_DIS: win = '0;
			endcase
		end
		default: begin // Capacitor
			win.upper = CAP_UPPER_CYC;
			unique case (sel_q)
			SEL_00:  win.lower = CAP_UPPER_CYC >> SH_R8;
			SEL_11:  win.lower = CAP_UPPER_CYC >> SH_R2;
			SEL_01:  win.lower = CAP_UPPER_CYC - (CAP_UPPER_CYC >> SH_R4);
			SEL_DIS: win.lower = '0;
			endcase
		end
		endcase
	end

	// Hold time by delay pin class
	// A capacitor hold is only a parameter here; its charge is analogue
	always_comb begin
		unique case (dkind)
		PIN_OPEN: hold = HOLD_OPEN_CYC;
		PIN_PU:   hold = HOLD_PU_CYC;
		default:  hold = CAP_HOLD_CYC;
		endcase
	end

	// Main sequencer; counter measures time since last kick or event
	always_comb begin
		st_d       = st_q;
		cnt_d      = cnt_q + 1'b1;
		sel_d      = sel_q;
		kick_d     = kick_s;
		capfault_d = capfault_q;
		wdo_d      = 1'b1;
		en_d       = 1'b0;
		pstart_d   = 1'b0;
		unique case (st_q)
		ST_PROBE: begin // Re-probe both pins each power-up
			cnt_d = '0;
			if (wdone) begin
				st_d  = ST_INIT;
				sel_d = live;
			end
		end
		ST_INIT: begin // Initial hold, disabled, fault high
			if (cnt_q >= hold - 1'b1) begin
				cnt_d = '0;
				sel_d = live;
				st_d  = dis_now ? ST_OFF : ST_SETTLE;
			end
		end
		ST_OFF: begin // Disabled: kicks ignored, output high
			cnt_d = '0;
			if (!dis_now) begin
				sel_d = live;
				// Capacitor hold interrupted: serve it in full first
				st_d = capfault_q ? ST_FAULT : ST_SETTLE;
			end
		end
		ST_SETTLE: begin // Kicks ignored while settling
			en_d = 1'b1;
			if (cnt_q >= SETTLE_CYC - 1'b1) begin
				cnt_d = '0;
				st_d  = ST_FIRST;
			end
		end
		ST_FIRST: begin // Plain timeout for the first kick
			en_d = 1'b1;
			if (fall) begin
				cnt_d = '0;
				st_d  = ST_WIN;
			end else if (cnt_q >= win.upper - 1'b1) begin
				cnt_d = '0;
				st_d  = ST_FAULT;
			end
		end
		ST_WIN: begin // Windowed kicks; a lower bound at or above the upper makes every kick a fault
			en_d = 1'b1;
			if (fall) begin
				cnt_d = '0;
				if (cnt_q < win.lower && cnt_q < win.upper)
					st_d = ST_FAULT;
			end else if (cnt_q >= win.upper - 1'b1) begin
				cnt_d = '0;
				st_d  = ST_FAULT;
			end
		end
		ST_FAULT: begin // Fault low, kicks ignored
			en_d       = 1'b1;
			wdo_d      = 1'b0;
			capfault_d = (dkind == PIN_CAP);
			if (cnt_q >= hold - 1'b1) begin
				cnt_d      = '0;
				capfault_d = 1'b0;
				sel_d      = live; // Timing change latched here
				st_d       = ST_SETTLE;
				en_d       = 1'b0;
			end
		end
		default: st_d = ST_PROBE;
		endcase
		// Disable acts at once, from any running state
		if (dis_now && st_q != ST_PROBE && st_q != ST_INIT) begin
			st_d  = ST_OFF;
			wdo_d = 1'b1;
			en_d  = 1'b0;
			if (st_q != ST_FAULT && st_q != ST_OFF)
				capfault_d = 1'b0;
		end
		// Undervoltage: restart, re-probe, relatch selects
		if (uv_s) begin
			st_d       = ST_PROBE;
			pstart_d   = 1'b1;
			capfault_d = 1'b0;
			wdo_d      = 1'b1;
			en_d       = 1'b0;
		end
	end

	// Sequencer registers; ce low freezes every one of them
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st_q       <= ST_PROBE;
			pstart_q   <= 1'b1;
			cnt_q      <= '0;
			sel_q      <= SEL_DIS;
			kick_q     <= 1'b0;
			capfault_q <= 1'b0;
			wdo_q      <= 1'b1;
			en_q       <= 1'b0;
		end else if (ce) begin
			st_q       <= st_d;
			pstart_q   <= pstart_d;
			cnt_q      <= cnt_d;
			sel_q      <= sel_d;
			kick_q     <= kick_d;
			capfault_q <= capfault_d;
			wdo_q      <= wdo_d;
			en_q       <= en_d;
		end
	end

	// Class registers come from flops in the probe modules
	assign fault_output_n = wdo_q;
	assign enabled        = en_q;
	assign window_kind    = wkind;
	assign hold_kind      = dkind;
endmodule

// ### logic/wwd_pkg.sv
// Package of constants and types for the window watchdog block
// Notes on behaviour
// - Probe each timing pin for a set period, classify open, pulled up or capacitor.
// - Re-probe the hold-time pin at every power-up.
// - Hold time is 200 ms with pin open, 10 ms when pulled up.
// - Capacitor window ratio: 1/8 for 00, 1/2 for 11, 3/4 for 01.
// - Select 10 disables: fault never asserts, kicks ignored.
// - Open window pin: lower 22.5, 1.85, 800 ms; upper 55, 27.5, 1600 ms.
// - At 3/4 ratio the lower bound may overlap the upper; tolerate it.
// - Timing-only select changes latch only at a fault or undervoltage reset.
// - A select change that disables takes effect at once.
// - After enabling, kicks are ignored for a 150 us settle period.
// - Capacitor hold: disable releases fault; re-enable waits a full hold time.
// - Preset hold: disable and re-enable during fault acts as a plain enable.
// - After first kick, each kick must fall inside the window, else fault.
// - First kick after enabling only needs to beat the upper bound.
// - On violation, fault low for hold time, kicks ignored meanwhile.
// - At power-up stay disabled, fault high, until an initial hold time ends.
package wwd_pkg;
	localparam int unsigned CLK_MHZ = 125;
	localparam int unsigned CW      = 32;
	// Times in microseconds as printed, counts derived (microseconds times CLK_MHZ, zero stays zero)
	localparam int unsigned PROBE_US  = 381;
	localparam int unsigned SETTLE_US = 150;
	localparam logic [CW-1:0] PROBE_CYC  = CW'(PROBE_US * CLK_MHZ);
	localparam logic [CW-1:0] SETTLE_CYC = CW'(SETTLE_US * CLK_MHZ);
	// Preset times in microseconds (typical figures)
	localparam int unsigned HOLD_OPEN_US = 200000;
	localparam int unsigned HOLD_PU_US   = 10000;
	localparam int unsigned LO_OPEN_00   = 22500;
	localparam int unsigned LO_OPEN_01   = 1850;
	localparam int unsigned LO_OPEN_11   = 800000;
	localparam int unsigned UP_OPEN_00   = 55000;
	localparam int unsigned UP_OPEN_01   = 27500;
	localparam int unsigned UP_OPEN_11   = 1600000;
	localparam int unsigned LO_PU_00     = 9000;
	localparam int unsigned LO_PU_01     = 9000;
	localparam int unsigned LO_PU_11     = 1850;
	localparam int unsigned UP_PU_00     = 109000;
	localparam int unsigned UP_PU_01     = 195000;
	localparam int unsigned UP_PU_11     = 11000;
	// Capacitor defaults: smallest-part upper bound, hold value arbitrary
	localparam int unsigned CAP_UP_US    = 62740;
	localparam int unsigned CAP_HOLD_US  = 12500;
	// Capacitor ratio shifts: lower = upper >> 3, >> 1, or upper - upper >> 2
	localparam int unsigned SH_R8 = 3;
	localparam int unsigned SH_R2 = 1;
	localparam int unsigned SH_R4 = 2;
	// Window select codes {sel1, sel0}
	localparam logic [1:0] SEL_00  = 2'h0;
	localparam logic [1:0] SEL_DIS = 2'h1;
	localparam logic [1:0] SEL_01  = 2'h2;
	localparam logic [1:0] SEL_11  = 2'h3;

	typedef enum logic [1:0] {
		PIN_OPEN = 2'b00,
		PIN_PU   = 2'b01,
		PIN_CAP  = 2'b10
	} wwd_pin_t;

	// Raw probe observation of one timing pin
	typedef struct packed {
		logic lvl_float; // Level with weak pull-down released
		logic lvl_slow;  // Level stayed low briefly after discharge: capacitor
	} wwd_probe_t;

	// Selected window bounds in clock cycles
	typedef struct packed {
		logic [CW-1:0] lower;
		logic [CW-1:0] upper;
	} wwd_win_t;

	function automatic logic [CW-1:0] wwd_us2cyc(input int unsigned us);
		wwd_us2cyc = CW'(us * CLK_MHZ);
	endfunction
endpackage

// ### logic/wwd_sync.sv
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module wwd_sync import wwd_pkg::*; #(
	parameter int unsigned W = 1
) (
	input  wire logic         mclk,
	input  wire logic         rst_n,
	input  wire logic         ce,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] s1_q, s1_d, s2_q, s2_d;

	// First stage feeds only the second
	always_comb begin
		s1_d = ce ? din : s1_q;
		s2_d = ce ? s1_q : s2_q;
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= '0;
			s2_q <= '0;
		end else begin
			s1_q <= s1_d;
			s2_q <= s2_d;
		end
	end

	assign dout = s2_q;
endmodule

// ### logic/wwd_probe.sv
// Timing-pin classifier run for a fixed probe period
`timescale 1ns/1ps
module wwd_probe import wwd_pkg::*; (
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic       ce,
	input  wire logic       start,
	input  wire wwd_probe_t obs,
	output wwd_pin_t        kind,
	output logic            done
);
	logic [CW-1:0] cnt_q, cnt_d;
	logic          run_q, run_d, done_q, done_d;
	logic          slow_q, slow_d;
	wwd_pin_t      kind_q, kind_d;

	// Count the probe period; a capacitor shows as a slow level seen any time
	always_comb begin
		cnt_d  = cnt_q;
		run_d  = run_q;
		done_d = 1'b0;
		slow_d = slow_q;
		kind_d = kind_q;
		if (start) begin
			run_d  = 1'b1;
			cnt_d  = '0;
			slow_d = 1'b0;
		end else if (run_q) begin
			slow_d = slow_q | obs.lvl_slow;
			if (cnt_q == PROBE_CYC - 1'b1) begin
				run_d  = 1'b0;
				done_d = 1'b1;
				if (slow_d)
					kind_d = PIN_CAP;
				else if (obs.lvl_float)
					kind_d = PIN_PU;
				else
					kind_d = PIN_OPEN;
			end else begin
				cnt_d = cnt_q + 1'b1;
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q  <= '0;
			run_q  <= 1'b0;
			done_q <= 1'b0;
			slow_q <= 1'b0;
			kind_q <= PIN_OPEN;
		end else if (ce) begin
			cnt_q  <= cnt_d;
			run_q  <= run_d;
			done_q <= done_d;
			slow_q <= slow_d;
			kind_q <= kind_d;
		end
	end

	assign kind = kind_q;
	assign done = done_q;
endmodule

// ### sim/wwd_monitor.sv
// Port checker for the window watchdog core
`timescale 1ns/1ps
module wwd_monitor import wwd_pkg::*; #(
	parameter logic [CW-1:0] HOLD_CYC = 32'h0000_0190
) (
	input wire logic       mclk,
	input wire logic       rstn,
	input wire logic       ce,
	input wire logic       uvlo,
	input wire logic       window_select_0,
	input wire logic       window_select_1,
	input wire logic       fault_output_n,
	input wire logic       enabled,
	input wire logic [1:0] window_kind,
	input wire logic [1:0] hold_kind
);
	logic          sel_dis;
	logic [CW-1:0] up_cnt_q;
	logic [CW-1:0] up_cnt_d;
	logic [CW-1:0] low_cnt_q;
	logic [CW-1:0] low_cnt_d;
	logic [CW-1:0] en_cnt_q;
	logic [CW-1:0] en_cnt_d;
	assign sel_dis = window_select_0 & ~window_select_1;
	// Counters: since start and time enabled saturate, fault low run wraps
	always_comb begin
		up_cnt_d  = uvlo ? '0 : up_cnt_q + CW'(ce & ~up_cnt_q[CW-1]);
		low_cnt_d = fault_output_n ? '0 : low_cnt_q + 1;
		en_cnt_d  = enabled ? en_cnt_q + CW'(~en_cnt_q[CW-1]) : '0;
	end
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			up_cnt_q  <= '0;
			low_cnt_q <= '0;
			en_cnt_q  <= '0;
		end else begin
			up_cnt_q  <= up_cnt_d;
			low_cnt_q <= low_cnt_d;
			en_cnt_q  <= en_cnt_d;
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rstn);
	// Six cycles covers the two-flop sync plus state and output regs
	sequence s_dis_held;
		sel_dis [*6];
	endsequence
	sequence s_fault_start;
		fault_output_n ##1 !fault_output_n;
	endsequence
	a_dis_quiet: assert property (
		s_dis_held |-> fault_output_n && !enabled)
		else $error("fault or enable seen while disabled");
	a_fault_cause: assert property (
		s_fault_start |-> enabled && !sel_dis)
		else $error("fault asserted while not running");
	a_settle_deaf: assert property (
		s_fault_start |-> en_cnt_q >= SETTLE_CYC)
		else $error("fault asserted inside settle period");
	a_start_quiet: assert property (
		up_cnt_q < PROBE_CYC + HOLD_CYC |-> !enabled && fault_output_n)
		else $error("watchdog active before probe and hold end");
	a_kinds_fixed: assert property (
		up_cnt_q > PROBE_CYC + 8 && !uvlo
		|-> $stable(window_kind) && $stable(hold_kind))
		else $error("pin class changed after probe");
	a_reset_out: assert property (
		$rose(rstn) |-> fault_output_n && !enabled
		&& window_kind == 2'h0 && hold_kind == 2'h0)
		else $error("outputs not idle at reset release");
	a_hold_max: assert property (
		low_cnt_q <= HOLD_CYC + 2)
		else $error("fault held longer than hold time");
	a_hold_min: assert property (
		$rose(fault_output_n) |-> sel_dis || low_cnt_q >= HOLD_CYC - 2)
		else $error("fault released before hold time");
endmodule

// ### sim/wwd_host.sv
// Host model that issues kick pulses on request
`timescale 1ns/1ps
module wwd_host #(
	parameter int unsigned LOW_CYC = 8
) (
	input  wire logic mclk,
	input  wire logic kick_req,
	output logic      kick_input
);
	int unsigned left = 0;
	initial kick_input = 1'b1;
	// Low for 64 ns at least, so the edge survives the synchroniser
	always @(negedge mclk) begin
		if (kick_req) begin
			kick_input <= 1'b0;
			left <= LOW_CYC;
		end else if (left > 0) begin
			left <= left - 1;
			if (left == 1) kick_input <= 1'b1;
		end
	end
endmodule

// ### sim/wwd_top_test.sv
// Self-checking bench for the window watchdog core
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin \
	num_errors++; $display("mismatch at %0t got %h exp %h", $time, \
	(a), (b)); end end
module wwd_top_test import wwd_pkg::*;;
	localparam logic [CW-1:0] HOLD = 32'h0000_0190;
	localparam logic [CW-1:0] LO00 = 32'h0000_012c;
	localparam logic [CW-1:0] UP00 = 32'h0000_03e8;
	logic       mclk     = 1'b0;
	logic       rstn     = 1'b0;
	logic       sel0     = 1'b0;
	logic       kick_req = 1'b0;
	wwd_probe_t pin_open = '0;
	logic       kick;
	logic       fault_n;
	logic       en;
	logic [1:0] wkind;
	logic [1:0] hkind;
	int         num_errors = 0;
	int         num_checks = 0;
	always #4 mclk = ~mclk;
	wwd_host u_host (.mclk(mclk), .kick_req(kick_req), .kick_input(kick));
	// Short window and hold keep the run near 90000 cycles
	wwd_top #(.HOLD_OPEN_CYC(HOLD), .LO_OPEN00_CYC(LO00),
		.UP_OPEN00_CYC(UP00)) DUT (
		.mclk(mclk), .rstn(rstn), .ce(1'b1), .uvlo(1'b0),
		.kick_input(kick), .window_select_0(sel0),
		.window_select_1(1'b0), .window_timing_pin(pin_open),
		.delay_timing_pin(pin_open), .fault_output_n(fault_n),
		.enabled(en), .window_kind(wkind), .hold_kind(hkind));
	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask
	// Falling kick edges land n cycles after the previous one
	task automatic kick_after(input int n);
		cyc(n - 1);
		kick_req <= 1'b1;
		cyc(1);
		kick_req <= 1'b0;
	endtask
	task automatic wait_lvl(ref logic s, input logic v, input int lim,
		output int n);
		n = 0;
		while (s !== v && n < lim) begin
			cyc(1);
			n++;
		end
	endtask
	task automatic t_startup();
		int n;
		cyc(1000);
		`CHK(en, 1'b0);
		`CHK(fault_n, 1'b1);
		wait_lvl(en, 1'b1, 70000, n);
		`CHK(en, 1'b1);
		`CHK(n + 1000 > int'(PROBE_CYC + HOLD), 1'b1);
		`CHK(wkind, PIN_OPEN);
		`CHK(hkind, PIN_OPEN);
	endtask
	// First kick early in the count, then both window edges
	task automatic t_window();
		cyc(int'(SETTLE_CYC) + 20);
		kick_after(1);
		kick_after(int'(LO00) + 10);
		kick_after(int'(UP00) - 10);
		cyc(20);
		`CHK(fault_n, 1'b1);
	endtask
	task automatic t_early();
		int n;
		kick_after(80);
		wait_lvl(fault_n, 1'b0, 12, n);
		`CHK(n < 12, 1'b1);
		`CHK(en, 1'b1);
	endtask
	// Disable in mid-fault with a preset hold; only one select moves
	task automatic t_disable();
		kick_after(30);
		sel0 <= 1'b1;
		cyc(6);
		`CHK(fault_n, 1'b1);
		`CHK(en, 1'b0);
		repeat (10) kick_after(150);
		`CHK(fault_n, 1'b1);
	endtask
	// A kick in the settle period must not start the count
	task automatic t_reenable();
		int n;
		sel0 <= 1'b0;
		cyc(6);
		`CHK(en, 1'b1);
		kick_after(int'(SETTLE_CYC) - 1000);
		wait_lvl(fault_n, 1'b0, int'(UP00) + 1100, n);
		`CHK(n > int'(UP00) + 980, 1'b1);
		`CHK(n < int'(UP00) + 1010, 1'b1);
		wait_lvl(fault_n, 1'b1, int'(HOLD) + 20, n);
		`CHK(n >= int'(HOLD) - 3, 1'b1);
		`CHK(n <= int'(HOLD) + 3, 1'b1);
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		cyc(10);
		rstn <= 1'b1;
		t_startup();
		t_window();
		t_early();
		t_disable();
		t_reenable();
		print_verdict();
	end
	// Guard against a hang; the sequence needs about 90000 cycles
	initial begin
		cyc(96000);
		num_errors++;
		print_verdict();
	end
endmodule
bind wwd_top wwd_monitor #(.HOLD_CYC(32'h0000_0190)) u_mon (
	.mclk(mclk), .rstn(rstn), .ce(ce), .uvlo(uvlo),
	.window_select_0(window_select_0), .window_select_1(window_select_1),
	.fault_output_n(fault_output_n), .enabled(enabled),
	.window_kind(window_kind), .hold_kind(hold_kind));
